// File: arc_pkg.sv
package arc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ARC_ADDR = 8'hd1;
  localparam logic [7:0] ARC_RESET = 8'h00;
  localparam logic [7:0] ARC_WR_MASK = 8'h0f;
  // enables after reset: only the sensor hi-z flag is up
  localparam logic [3:0] ARC_EN_RESET = 4'h2;
  // ==========================================================
  // field positions
  localparam int ARC_BIT_SRC_SEL = 3;
  localparam int ARC_BIT_TEMP_EN = 2;
  localparam int ARC_BIT_BIAS_EN = 1;
  localparam int ARC_BIT_BUF_EN = 0;
  // number of peripherals that can demand the bias generator
  localparam int ARC_NUM_BIAS_REQ = 4;
  // ==========================================================
  // sfr access phases
  typedef enum logic [1:0] {
    ARC_IDLE,
    ARC_WRITE,
    ARC_READ
  } arc_access_t;
endpackage

// File: arc_bias_or.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bias generator demand combiner
module arc_bias_or
  import arc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic manual_en,
  input wire logic [ARC_NUM_BIAS_REQ-1:0] periph_req,
  output logic bias_on_q
);
  logic bias_on_d;
  logic [ARC_NUM_BIAS_REQ:0] chain;

  // or chain, one stage per requesting peripheral
  assign chain[0] = manual_en;
  genvar gi;
  generate
    for (gi = 0; gi < ARC_NUM_BIAS_REQ; gi++) begin : g_req
      assign chain[gi+1] = chain[gi] | periph_req[gi];
    end
  endgenerate

  always_comb begin
    bias_on_d = chain[ARC_NUM_BIAS_REQ];
  end

  // registered so the pin output is glitch free
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bias_on_q <= 1'b0;
    end else begin
      bias_on_q <= bias_on_d;
    end
  end
endmodule // arc_bias_or
`default_nettype wire

// File: arc_reference_control.sv
// Contract
// - the register sits at sfr address 0xd1, bits 7 to 4 read zero and ignore writes.
// - reset clears the whole register to zero.
// - bit 3 selects the reference, 0 the external pin and 1 the supply.
// - bit 2 turns the temperature sensor on, and while off its output is high impedance.
// - bit 1 forces the bias generator on, otherwise only the automatic term applies.
// - the bias generator is on when converter, sensor, oscillator or current dac is on, or-ed.
// - bit 0 enables the reference output buffer that drives the reference pin.
`timescale 1ns/1ps
`default_nettype none
module arc_reference_control
  import arc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic adc_enable,
  input wire logic osc_enable,
  input wire logic idac_enable,
  output logic reference_source_select,
  output logic temp_sensor_enable,
  output logic temp_sensor_hiz,
  output logic bias_generator_enable,
  output logic reference_buffer_enable
);
  // ==========================================================
  // register state
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  arc_access_t access;
  logic hit;

  assign hit = (sfr_addr == ARC_ADDR);

  // decode the access phase; write wins if both strobes are up
  always_comb begin
    if (hit && sfr_wr) begin
      access = ARC_WRITE;
    end else if (hit && sfr_rd) begin
      access = ARC_READ;
    end else begin
      access = ARC_IDLE;
    end
  end

  // next register and read data
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    case (access)
      ARC_WRITE: begin
        ctrl_d = sfr_wdata & ARC_WR_MASK;
      end
      ARC_READ: begin
        rdata_d = ctrl_q & ARC_WR_MASK;
      end
      ARC_IDLE: begin
        rdata_d = rdata_q;
      end
      default: begin
        ctrl_d = ctrl_q;
      end
    endcase
  end

  // read data held until the next read so the core may sample late
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= ARC_RESET;
      rdata_q <= ARC_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // enables
  logic [3:0] en_d;
  logic [3:0] en_q;
  logic bias_q;

  always_comb begin
    en_d[3] = ctrl_d[ARC_BIT_SRC_SEL];
    en_d[2] = ctrl_d[ARC_BIT_TEMP_EN];
    en_d[1] = ~ctrl_d[ARC_BIT_TEMP_EN];
    en_d[0] = ctrl_d[ARC_BIT_BUF_EN];
  end

  // enables follow the register on the same edge as the write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= ARC_EN_RESET;
    end else begin
      en_q <= en_d;
    end
  end

  // bias demand is one cycle behind its inputs
  arc_bias_or u_bias (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .manual_en(ctrl_q[ARC_BIT_BIAS_EN]),
    .periph_req({idac_enable, osc_enable, ctrl_q[ARC_BIT_TEMP_EN], adc_enable}),
    .bias_on_q(bias_q)
  );

  assign sfr_rdata = rdata_q;
  assign reference_source_select = en_q[3];
  assign temp_sensor_enable = en_q[2];
  assign temp_sensor_hiz = en_q[1];
  assign reference_buffer_enable = en_q[0];
  assign bias_generator_enable = bias_q;

  // ==========================================================
  // access sequences shared by the checks below
  // a write strobe addressed to this register
  sequence s_ctrl_write;
    hit && sfr_wr;
  endsequence

  // a read strobe addressed here with no write beside it
  sequence s_ctrl_read;
    hit && sfr_rd && !sfr_wr;
  endsequence

  // both strobes in one cycle; the write is taken, the read dropped
  sequence s_both_strobes;
    hit && sfr_wr && sfr_rd;
  endsequence

  // a write that sets the manual bias bit
  sequence s_bias_write;
    hit && sfr_wr && sfr_wdata[ARC_BIT_BIAS_EN];
  endsequence

  // a write that turns the sensor on, which also pulls the bias in
  sequence s_temp_write;
    hit && sfr_wr && sfr_wdata[ARC_BIT_TEMP_EN];
  endsequence

  // no source of bias demand is up
  sequence s_no_bias_demand;
    !(ctrl_q[ARC_BIT_BIAS_EN] | ctrl_q[ARC_BIT_TEMP_EN] | adc_enable | osc_enable
      | idac_enable);
  endsequence

  // ==========================================================
  // register checks
  // the unused nibble can never hold a one
  AST_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ctrl_q[7:4] == 4'h0) else $error("upper bits not zero");

  // a taken write lands, masked, on the strobe edge
  AST_WRITE_TAKES: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_ctrl_write |=> ctrl_q == ($past(sfr_wdata) & ARC_WR_MASK))
    else $error("write lost");

  // a read returns the register as it stood at the strobe
  AST_READ_DATA: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_ctrl_read |=> sfr_rdata == $past(ctrl_q)) else $error("bad read");

  // without a write strobe here the register keeps its value
  AST_NO_STRAY_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(hit && sfr_wr) |=> $stable(ctrl_q)) else $error("stray write");

  // read data stands until the next taken read, so a slow core still sees it
  AST_READ_HOLDS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(hit && sfr_rd && !sfr_wr) |=> $stable(sfr_rdata)) else $error("read data moved");

  // with both strobes the write lands and the read data stays
  AST_WRITE_WINS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_both_strobes |=> $stable(sfr_rdata) && ctrl_q == ($past(sfr_wdata) & ARC_WR_MASK))
    else $error("both strobes mishandled");

  // read data never shows the unused nibble
  AST_RDATA_UPPER: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sfr_rdata[7:4] == 4'h0) else $error("read data upper bits set");

  // ==========================================================
  // enable checks
  // the source select pin mirrors its register bit
  AST_SRC_SEL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reference_source_select == ctrl_q[3]) else $error("source select mismatch");

  // the hi-z flag is always the inverse of the sensor enable
  AST_TEMP_HIZ: assert property (@(posedge ref_clk) disable iff (!reset_n)
    temp_sensor_hiz == !temp_sensor_enable && temp_sensor_enable == ctrl_q[2])
    else $error("sensor state wrong");

  // the buffer enable pin mirrors its register bit
  AST_BUF_EN: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reference_buffer_enable == ctrl_q[0]) else $error("buffer enable mismatch");

  // a write reaches the source select, sensor and buffer enable pins one edge later, never two
  AST_WRITE_PINS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_ctrl_write |=> reference_source_select == $past(sfr_wdata[ARC_BIT_SRC_SEL])
    && temp_sensor_enable == $past(sfr_wdata[ARC_BIT_TEMP_EN])
    && reference_buffer_enable == $past(sfr_wdata[ARC_BIT_BUF_EN]))
    else $error("enables late after write");

  // ==========================================================
  // bias checks
  // the generator follows the or of all demands one edge late
  AST_BIAS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 bias_generator_enable == $past(ctrl_q[1] | ctrl_q[2] | adc_enable
    | osc_enable | idac_enable)) else $error("bias enable wrong");

  // a manual enable write turns the generator on two edges later
  AST_BIAS_MANUAL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_bias_write |-> ##2 bias_generator_enable) else $error("manual bias not on");

  // turning the sensor on pulls the generator in as well
  AST_TEMP_BIAS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_temp_write |-> ##2 bias_generator_enable) else $error("sensor did not pull bias");

  // with no demand at all the generator drops on the next edge
  AST_BIAS_IDLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_no_bias_demand |=> !bias_generator_enable) else $error("bias on without demand");
endmodule // arc_reference_control
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import arc_pkg::*;
;
  // ==========================================================
  // clock, reset and design hookup
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [2:0] periph = 3'h0;
  logic src, temp, hiz, bias, buf_en;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  arc_reference_control arc_reference_control_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .adc_enable(periph[0]), .osc_enable(periph[1]),
    .idac_enable(periph[2]), .reference_source_select(src), .temp_sensor_enable(temp),
    .temp_sensor_hiz(hiz), .bias_generator_enable(bias), .reference_buffer_enable(buf_en));
  // ==========================================================
  // helpers
  // expected enables packed as {src, temp, hiz, bias, buf}
  function automatic logic [7:0] exp_outs(input logic [3:0] r, input logic [2:0] p);
    return {3'h0, r[3], r[2], ~r[2], r[1] | r[2] | (|p), r[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_outs(input logic [7:0] exp);
    chk({3'h0, src, temp, hiz, bias, buf_en}, exp);
  endtask
  // write strobe for one cycle, then one more cycle so bias has settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  // two writes on consecutive edges, strobe held up between them
  task automatic wr_pair(input logic [7:0] d0, input logic [7:0] d1);
    @(negedge ref_clk);
    sfr_addr = ARC_ADDR;
    sfr_wdata = d0;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wdata = d1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  // both strobes in one cycle, then one more cycle for bias
  task automatic both(input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = ARC_ADDR;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd_at(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask
  task automatic rd(input logic [7:0] exp);
    rd_at(ARC_ADDR, exp);
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, far above the roughly 135 cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ==========================================================
  // test sequence
  initial begin
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    chk_outs(exp_outs(4'h0, 3'h0));
    rd(ARC_RESET);
    // every low-nibble value, upper bits always written as ones
    for (int i = 0; i < 16; i++) begin
      wr(ARC_ADDR, 8'hf0 | 8'(i));
      chk_outs(exp_outs(4'(i), 3'h0));
      rd(8'(i));
    end
    // other address must not touch the register
    wr(8'hd0, 8'h00);
    chk_outs(exp_outs(4'hf, 3'h0));
    wr(ARC_ADDR, 8'h00);
    chk_outs(exp_outs(4'h0, 3'h0));
    // automatic bias demand from each peripheral mix, one cycle late
    for (int p = 0; p < 8; p++) begin
      @(negedge ref_clk);
      periph = 3'(p);
      @(negedge ref_clk);
      chk_outs(exp_outs(4'h0, 3'(p)));
    end
    @(negedge ref_clk);
    periph = 3'h0;
    // both strobes: the write lands, the last read data stays
    both(8'h05);
    chk(sfr_rdata, 8'h0f);
    chk_outs(exp_outs(4'h5, 3'h0));
    rd(8'h05);
    // a read strobe at another address leaves the read data alone
    wr(ARC_ADDR, 8'h0a);
    rd_at(8'hd2, 8'h05);
    rd(8'h0a);
    // back to back writes, the second one wins
    wr_pair(8'h02, 8'h08);
    chk_outs(exp_outs(4'h8, 3'h0));
    rd(8'h08);
    // second reset in mid-run clears the register and all enables but the sensor hi-z flag, which comes up
    wr(ARC_ADDR, 8'h0f);
    @(negedge ref_clk);
    reset_n = 1'b0;
    @(negedge ref_clk);
    chk_outs(exp_outs(4'h0, 3'h0));
    reset_n = 1'b1;
    rd(ARC_RESET);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
